/* File: src/rrx_map.svh */
// opcode constants, register widths and reset values for the transfer/exchange block
// Functional notes
// - The decrement exchange swaps A with RAM at the data pointer and sets X to X xor j in one cycle.
// - The decrement exchange also lowers Y by one and skips the next instruction when Y becomes 15.
// - The increment exchange swaps A with RAM at the data pointer and sets X to X xor j.
// - The increment exchange raises Y by one and skips the next instruction when Y becomes 0.
// - After the increment exchange a nonzero Y lets the next instruction run normally.
// - The increment exchange is a one-word, one-cycle instruction that leaves carry untouched.
// - Four one-cycle moves: A from B, B from A, A from Y and Y from A.
// - Opcode 0x01A loads E upper nibble from B and E lower nibble from A.
// - Opcode 0x02A loads B from E upper nibble and A from E lower nibble.
// - Opcode 0x051 copies the direction register into A with A3 cleared; 0x029 writes A2..A0 into it.
`ifndef RRX_MAP_SVH
`define RRX_MAP_SVH
`define OPC_XCHG_DEC_HI   6'h2F
`define OPC_XCHG_INC_HI   6'h2E
`define OPC_ACC_FROM_B    10'h01E
`define OPC_B_FROM_ACC    10'h00E
`define OPC_ACC_FROM_Y    10'h01F
`define OPC_Y_FROM_ACC    10'h00C
`define OPC_EXT_FROM_BA   10'h01A
`define OPC_BA_FROM_EXT   10'h02A
`define OPC_DIR_FROM_ACC  10'h029
`define OPC_ACC_FROM_DIR  10'h051
`define NIB_ZERO          4'h0
`define NIB_ONE           4'h1
`define NIB_MAX           4'hF
`define EXT_RST           8'h00
`define DIR_RST           3'h0
`define IMM_MSB           3
`define IMM_LSB           0
`define EXT_HI_MSB        7
`define EXT_HI_LSB        4
`define EXT_LO_MSB        3
`define EXT_LO_LSB        0
`define DIR_MSB           2
`define ACC_TOP           3
`endif

/* File: src/rrx_pkg.sv */
// types shared by the transfer/exchange block
package rrx_pkg;
  typedef enum logic [3:0] {
    OP_NONE     = 4'b0000,
    OP_XCHG_DEC = 4'b0001,
    OP_XCHG_INC = 4'b0010,
    OP_A_FROM_B = 4'b0011,
    OP_B_FROM_A = 4'b0100,
    OP_A_FROM_Y = 4'b0101,
    OP_Y_FROM_A = 4'b0110,
    OP_E_FROM_BA = 4'b0111,
    OP_BA_FROM_E = 4'b1000,
    OP_D_FROM_A = 4'b1001,
    OP_A_FROM_D = 4'b1010
  } op_t;
  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] b;
    logic [3:0] x;
    logic [3:0] y;
    logic [7:0] ext;
    logic [2:0] dir;
  } regs_t;
endpackage : rrx_pkg

/* File: src/rrx_decode.sv */
// opcode classifier for the transfer/exchange group
`timescale 1ns/1ps
`include "rrx_map.svh"
module rrx_decode
  import rrx_pkg::*;
(
  // instruction word
  input  wire logic [9:0] code,
  // decoded operation
  output op_t             op
);
  function automatic op_t classify(input logic [9:0] c);
    op_t r;
    r = OP_NONE;
    if (c[9:4] == `OPC_XCHG_DEC_HI) r = OP_XCHG_DEC;
    else if (c[9:4] == `OPC_XCHG_INC_HI) r = OP_XCHG_INC;
    else begin
      case (c)
        `OPC_ACC_FROM_B:   r = OP_A_FROM_B;
        `OPC_B_FROM_ACC:   r = OP_B_FROM_A;
        `OPC_ACC_FROM_Y:   r = OP_A_FROM_Y;
        `OPC_Y_FROM_ACC:   r = OP_Y_FROM_A;
        `OPC_EXT_FROM_BA:  r = OP_E_FROM_BA;
        `OPC_BA_FROM_EXT:  r = OP_BA_FROM_E;
        `OPC_DIR_FROM_ACC: r = OP_D_FROM_A;
        `OPC_ACC_FROM_DIR: r = OP_A_FROM_D;
        default:           r = OP_NONE;
      endcase
    end
    return r;
  endfunction : classify

  assign op = classify(code);
endmodule : rrx_decode

/* File: src/rrx_exec.sv */
// execution of register transfers and accumulator/RAM exchanges
`timescale 1ns/1ps
`include "rrx_map.svh"
module rrx_exec
  import rrx_pkg::*;
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  // instruction from fetch, one per cycle
  input  wire logic       INSN_VALID,
  input  wire logic [9:0] INSN_CODE,
  // RAM nibble at the data pointer
  input  wire logic [3:0] MEM_RDATA,
  output logic            MEM_WE,
  output logic [3:0]      MEM_WDATA,
  // architectural registers
  output logic [3:0]      ACC,
  output logic [3:0]      B_REG,
  output logic [3:0]      X_REG,
  output logic [3:0]      Y_REG,
  output logic [7:0]      EXT_REG,
  output logic [2:0]      DIR_REG,
  // status
  output logic            SKIP_PENDING,
  output logic            INSN_SKIPPED,
  output logic            CARRY_WE
);
  op_t        op;
  regs_t      r_ff;
  regs_t      nxt_r;
  logic       skip_ff;
  logic       nxt_skip;
  logic       skipped_ff;
  wire        live;
  wire  [3:0] y_dec;
  wire  [3:0] y_inc;
  wire  [3:0] x_new;

  rrx_decode u_dec (
    .code (INSN_CODE),
    .op   (op)
  );

  assign live  = INSN_VALID && !skip_ff;
  assign y_dec = r_ff.y - `NIB_ONE;
  assign y_inc = r_ff.y + `NIB_ONE;
  assign x_new = r_ff.x ^ INSN_CODE[`IMM_MSB:`IMM_LSB];

  always_comb begin
    nxt_r    = r_ff;
    nxt_skip = skip_ff;
    if (INSN_VALID) begin
      nxt_skip = 1'b0;
    end
    if (live) begin
      case (op)
        OP_XCHG_DEC: begin
          nxt_r.acc = MEM_RDATA;
          nxt_r.x   = x_new;
          nxt_r.y   = y_dec;
          nxt_skip  = (y_dec == `NIB_MAX);
        end
        OP_XCHG_INC: begin
          nxt_r.acc = MEM_RDATA;
          nxt_r.x   = x_new;
          nxt_r.y   = y_inc;
          nxt_skip  = (y_inc == `NIB_ZERO);
        end
        OP_A_FROM_B: nxt_r.acc = r_ff.b;
        OP_B_FROM_A: nxt_r.b = r_ff.acc;
        OP_A_FROM_Y: nxt_r.acc = r_ff.y;
        OP_Y_FROM_A: nxt_r.y = r_ff.acc;
        // pack b and acc into e
        OP_E_FROM_BA: nxt_r.ext = {r_ff.b, r_ff.acc};
        // unpack e into b and acc
        OP_BA_FROM_E: begin
          nxt_r.b   = r_ff.ext[`EXT_HI_MSB:`EXT_HI_LSB];
          nxt_r.acc = r_ff.ext[`EXT_LO_MSB:`EXT_LO_LSB];
        end
        OP_D_FROM_A: nxt_r.dir = r_ff.acc[`DIR_MSB:0];
        OP_A_FROM_D: nxt_r.acc = {1'b0, r_ff.dir};
        default: nxt_r = r_ff;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      r_ff         <= '{acc: `NIB_ZERO, b: `NIB_ZERO, x: `NIB_ZERO, y: `NIB_ZERO,
                        ext: `EXT_RST, dir: `DIR_RST};
      skip_ff      <= 1'b0;
      skipped_ff   <= 1'b0;
    end else begin
      r_ff         <= nxt_r;
      skip_ff      <= nxt_skip;
      skipped_ff   <= INSN_VALID && skip_ff;
    end
  end

  // memory write is combinational in the exchange cycle so ram sees old acc
  assign MEM_WE       = live && (op == OP_XCHG_DEC || op == OP_XCHG_INC);
  assign MEM_WDATA    = r_ff.acc;
  assign ACC          = r_ff.acc;
  assign B_REG        = r_ff.b;
  assign X_REG        = r_ff.x;
  assign Y_REG        = r_ff.y;
  assign EXT_REG      = r_ff.ext;
  assign DIR_REG      = r_ff.dir;
  assign SKIP_PENDING = skip_ff;
  assign INSN_SKIPPED = skipped_ff;
  assign CARRY_WE     = 1'b0;

  property p_dec_swap;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_DEC) |=> (ACC == $past(MEM_RDATA)) &&
        (X_REG == ($past(X_REG) ^ $past(INSN_CODE[`IMM_MSB:`IMM_LSB])));
  endproperty
  a_dec_swap: assert property (p_dec_swap) else $error("dec exchange wrong");

  property p_dec_skip;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_DEC) |=> (Y_REG == $past(Y_REG) - `NIB_ONE) &&
        (SKIP_PENDING == (Y_REG == `NIB_MAX));
  endproperty
  a_dec_skip: assert property (p_dec_skip) else $error("dec skip wrong");

  property p_inc_swap;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_INC) |-> MEM_WE ##1 (ACC == $past(MEM_RDATA));
  endproperty
  a_inc_swap: assert property (p_inc_swap) else $error("inc exchange wrong");

  property p_inc_skip;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_INC && Y_REG == `NIB_MAX) |=> SKIP_PENDING;
  endproperty
  a_inc_skip: assert property (p_inc_skip) else $error("inc skip missing");

  property p_inc_noskip;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_INC && Y_REG != `NIB_MAX) |=> !SKIP_PENDING && Y_REG != `NIB_ZERO;
  endproperty
  a_inc_noskip: assert property (p_inc_noskip) else $error("inc spurious skip");

  property p_moves;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_A_FROM_Y) |=> (ACC == $past(Y_REG)) && $stable(Y_REG);
  endproperty
  a_moves: assert property (p_moves) else $error("acc from y wrong");

  property p_ext_pack;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_E_FROM_BA) |=> EXT_REG == {$past(B_REG), $past(ACC)};
  endproperty
  a_ext_pack: assert property (p_ext_pack) else $error("ext pack wrong");

  property p_ext_unpack;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_BA_FROM_E) |=>
        (B_REG == $past(EXT_REG[`EXT_HI_MSB:`EXT_HI_LSB])) &&
        (ACC == $past(EXT_REG[`EXT_LO_MSB:`EXT_LO_LSB])) && $stable(EXT_REG);
  endproperty
  a_ext_unpack: assert property (p_ext_unpack) else $error("ext unpack wrong");

  property p_dir;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_A_FROM_D) |=> (ACC[`ACC_TOP] == 1'b0) && (ACC[`DIR_MSB:0] == DIR_REG);
  endproperty
  a_dir: assert property (p_dir) else $error("acc from dir wrong");

  property p_squash;
    @(posedge CLK) disable iff (SYS_RST)
      (INSN_VALID && SKIP_PENDING) |-> !MEM_WE ##1 ($stable(ACC) && $stable(Y_REG) && INSN_SKIPPED);
  endproperty
  a_squash: assert property (p_squash) else $error("skipped word executed");

  property p_carry;
    @(posedge CLK) disable iff (SYS_RST) !CARRY_WE [*2];
  endproperty
  a_carry: assert property (p_carry) else $error("carry touched");

  // write data must be the old acc, not the swapped-in nibble
  property p_dec_wr;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_DEC) |-> MEM_WE && (MEM_WDATA == ACC);
  endproperty
  a_dec_wr: assert property (p_dec_wr) else $error("dec write wrong");

  property p_dec_noskip;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_DEC && Y_REG != `NIB_ZERO) |=> !SKIP_PENDING;
  endproperty
  a_dec_noskip: assert property (p_dec_noskip) else $error("dec spurious skip");

  property p_dec_keep;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_DEC) |=> $stable(B_REG) && $stable(EXT_REG) && $stable(DIR_REG);
  endproperty
  a_dec_keep: assert property (p_dec_keep) else $error("dec touched other reg");

  property p_inc_xor;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_INC) |=>
        X_REG == ($past(X_REG) ^ $past(INSN_CODE[`IMM_MSB:`IMM_LSB]));
  endproperty
  a_inc_xor: assert property (p_inc_xor) else $error("inc xor wrong");

  property p_inc_wr;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_INC) |-> MEM_WDATA == ACC;
  endproperty
  a_inc_wr: assert property (p_inc_wr) else $error("inc write wrong");

  property p_inc_keep;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_INC) |=> $stable(B_REG) && $stable(EXT_REG) && $stable(DIR_REG);
  endproperty
  a_inc_keep: assert property (p_inc_keep) else $error("inc touched other reg");

  property p_inc_y;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_INC) |=> Y_REG == $past(Y_REG) + `NIB_ONE;
  endproperty
  a_inc_y: assert property (p_inc_y) else $error("inc y wrong");

  property p_inc_carry;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_INC) |-> !CARRY_WE;
  endproperty
  a_inc_carry: assert property (p_inc_carry) else $error("inc wrote carry");

  property p_a_from_b;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_A_FROM_B) |=> (ACC == $past(B_REG)) && $stable(B_REG);
  endproperty
  a_a_from_b: assert property (p_a_from_b) else $error("acc from b wrong");

  property p_b_from_a;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_B_FROM_A) |=> (B_REG == $past(ACC)) && $stable(ACC);
  endproperty
  a_b_from_a: assert property (p_b_from_a) else $error("b from acc wrong");

  property p_y_from_a;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_Y_FROM_A) |=> (Y_REG == $past(ACC)) && $stable(ACC);
  endproperty
  a_y_from_a: assert property (p_y_from_a) else $error("y from acc wrong");

  property p_moves_no_we;
    @(posedge CLK) disable iff (SYS_RST)
      MEM_WE |-> live && (op == OP_XCHG_DEC || op == OP_XCHG_INC);
  endproperty
  a_moves_no_we: assert property (p_moves_no_we) else $error("stray ram write");

  property p_dir_wr;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_D_FROM_A) |=> (DIR_REG == $past(ACC[`DIR_MSB:0])) && $stable(ACC);
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("dir from acc wrong");

  // gaps in the word stream must neither execute nor eat a skip
  property p_idle_hold;
    @(posedge CLK) disable iff (SYS_RST)
      !INSN_VALID |=> $stable(ACC) && $stable(Y_REG) && $stable(X_REG) && $stable(SKIP_PENDING);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle cycle changed state");

  property p_skip_clear;
    @(posedge CLK) disable iff (SYS_RST)
      (INSN_VALID && SKIP_PENDING) |=> !SKIP_PENDING;
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("skip not consumed");

  property p_skipped_only;
    @(posedge CLK) disable iff (SYS_RST)
      !(INSN_VALID && SKIP_PENDING) |=> !INSN_SKIPPED;
  endproperty
  a_skipped_only: assert property (p_skipped_only) else $error("spurious skipped pulse");

  // unlisted words are no-ops, nothing may move
  property p_unlisted;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_NONE) |=> $stable(ACC) && $stable(B_REG) && $stable(Y_REG) &&
        $stable(EXT_REG) && $stable(DIR_REG) && !SKIP_PENDING;
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted word acted");

  property p_y_wrap;
    @(posedge CLK) disable iff (SYS_RST)
      (live && op == OP_XCHG_INC && Y_REG == `NIB_MAX) |=> Y_REG == `NIB_ZERO;
  endproperty
  a_y_wrap: assert property (p_y_wrap) else $error("y did not wrap");
endmodule : rrx_exec

/* File: verification/nib_ram_model.sv */
// ram nibble at the data pointer, as the fetch side would present it
`timescale 1ns/1ps
module nib_ram_model (
  // clock
  input  wire logic       CLK,
  // exchange port
  input  wire logic       MEM_WE,
  input  wire logic [3:0] MEM_WDATA,
  output logic [3:0]      MEM_RDATA,
  // preload from bench
  input  wire logic       LOAD_EN,
  input  wire logic [3:0] LOAD_VAL
);
  logic [3:0] cell_ff;
  // read is combinational: the exchange needs it in the same cycle
  assign MEM_RDATA = cell_ff;
  always_ff @(posedge CLK) begin
    if (LOAD_EN) cell_ff <= LOAD_VAL;
    else if (MEM_WE) cell_ff <= MEM_WDATA;
  end
endmodule : nib_ram_model

/* File: verification/testbench.sv */
// self-checking bench for the transfer/exchange block
`timescale 1ns/1ps
module testbench;
  import rrx_pkg::*;
  logic       CLK, SYS_RST, INSN_VALID, LOAD_EN, MEM_WE, SKIP_PENDING, INSN_SKIPPED, CARRY_WE;
  logic [9:0] INSN_CODE;
  logic [3:0] MEM_RDATA, MEM_WDATA, ACC, B_REG, X_REG, Y_REG, LOAD_VAL;
  logic [7:0] EXT_REG;
  logic [2:0] DIR_REG;
  int         err_count, samples_checked;
  rrx_exec u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .INSN_VALID(INSN_VALID), .INSN_CODE(INSN_CODE),
    .MEM_RDATA(MEM_RDATA), .MEM_WE(MEM_WE), .MEM_WDATA(MEM_WDATA), .ACC(ACC), .B_REG(B_REG),
    .X_REG(X_REG), .Y_REG(Y_REG), .EXT_REG(EXT_REG), .DIR_REG(DIR_REG),
    .SKIP_PENDING(SKIP_PENDING), .INSN_SKIPPED(INSN_SKIPPED), .CARRY_WE(CARRY_WE));
  nib_ram_model u_ram (.CLK(CLK), .MEM_WE(MEM_WE), .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA), .LOAD_EN(LOAD_EN), .LOAD_VAL(LOAD_VAL));
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // drive one word; back-to-back calls keep valid high
  task automatic step(input logic [9:0] code, input logic we);
    INSN_VALID = 1'b1;
    INSN_CODE = code;
    #1;
    chk("mem_we", {7'h00, we}, {7'h00, MEM_WE});
    chk("carry_we", 8'h00, {7'h00, CARRY_WE});
    @(negedge CLK);
  endtask : step
  task automatic idle(input logic ld, input logic [3:0] v);
    INSN_VALID = 1'b0;
    LOAD_EN = ld;
    LOAD_VAL = v;
    @(negedge CLK);
    LOAD_EN = 1'b0;
  endtask : idle
  task automatic regs(input logic [3:0] a, input logic [3:0] b, input logic [3:0] x,
                      input logic [3:0] y);
    chk("acc", {4'h0, a}, {4'h0, ACC});
    chk("b_reg", {4'h0, b}, {4'h0, B_REG});
    chk("x_reg", {4'h0, x}, {4'h0, X_REG});
    chk("y_reg", {4'h0, y}, {4'h0, Y_REG});
  endtask : regs
  task automatic t_dec;
    idle(1'b1, 4'h9);
    step(10'h2F5, 1'b1);
    regs(4'h9, 4'h0, 4'h5, 4'hF);
    chk("ram", 8'h00, {4'h0, MEM_RDATA});
    chk("skip_pending", 8'h01, {7'h00, SKIP_PENDING});
    step(10'h01F, 1'b0);
    chk("acc", 8'h09, {4'h0, ACC});
    chk("insn_skipped", 8'h01, {7'h00, INSN_SKIPPED});
    step(10'h01F, 1'b0);
    chk("acc", 8'h0F, {4'h0, ACC});
    $display("test dec done");
  endtask : t_dec
  task automatic t_inc;
    idle(1'b1, 4'h6);
    step(10'h2EA, 1'b1);
    regs(4'h6, 4'h0, 4'hF, 4'h0);
    chk("ram", 8'h0F, {4'h0, MEM_RDATA});
    idle(1'b0, 4'h0);
    chk("skip_pending", 8'h01, {7'h00, SKIP_PENDING});
    step(10'h01E, 1'b0);
    chk("acc", 8'h06, {4'h0, ACC});
    step(10'h2E3, 1'b1);
    regs(4'hF, 4'h0, 4'hC, 4'h1);
    chk("skip_pending", 8'h00, {7'h00, SKIP_PENDING});
    step(10'h01E, 1'b0);
    chk("acc", 8'h00, {4'h0, ACC});
    $display("test inc done");
  endtask : t_inc
  task automatic t_moves;
    idle(1'b1, 4'hD);
    step(10'h2E0, 1'b1);
    step(10'h00E, 1'b0);
    step(10'h01F, 1'b0);
    step(10'h01A, 1'b0);
    chk("ext_reg", 8'hD2, EXT_REG);
    step(10'h01E, 1'b0);
    step(10'h00C, 1'b0);
    step(10'h029, 1'b0);
    chk("dir_reg", 8'h05, {5'h00, DIR_REG});
    step(10'h02A, 1'b0);
    regs(4'h2, 4'hD, 4'hC, 4'hD);
    // unlisted word must leave everything alone
    step(10'h3FF, 1'b0);
    step(10'h051, 1'b0);
    regs(4'h5, 4'hD, 4'hC, 4'hD);
    chk("ext_reg", 8'hD2, EXT_REG);
    $display("test moves done");
  endtask : t_moves
  initial begin
    err_count = 0;
    samples_checked = 0;
    SYS_RST = 1'b1;
    INSN_VALID = 1'b0;
    INSN_CODE = 10'h000;
    LOAD_EN = 1'b0;
    LOAD_VAL = 4'h0;
    repeat (8) @(negedge CLK);
    SYS_RST = 1'b0;
    regs(4'h0, 4'h0, 4'h0, 4'h0);
    chk("ext_reg", 8'h00, EXT_REG);
    t_dec;
    t_inc;
    t_moves;
    complete_run;
  end
  // about thirty cycles of work; a thousand means a hang
  initial begin
    #8000;
    err_count++;
    complete_run;
  end
endmodule : testbench
